/* File: hdl/ubgfi_pkg.sv */
// shared constants and types for the rate divider and fifo status block
package ubgfi_pkg;

  // ************
  // register map
  // ************
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_MASK = 4'h1;
  localparam logic [3:0] IDX_CAUSE = 4'h2;
  localparam logic [3:0] IDX_LINE_CTRL = 4'h3;
  localparam logic [3:0] IDX_LINE_STATE = 4'h5;
  localparam logic [3:0] IDX_CONFIG = 4'h8;

  // ************
  // fields
  // ************
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PAREN = 3;
  localparam int LCR_DIV_SEL = 7;
  localparam int FCR_EN = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int FCR_TRIG = 6;
  localparam int IMR_RDA = 0;
  localparam int IMR_TX_HOLDING_EMPTY = 1;
  localparam int IMR_LSI = 2;

  // interrupt cause codes, low nibble of the cause register
  localparam logic [3:0] CAUSE_NONE = 4'h1;
  localparam logic [3:0] CAUSE_LSI = 4'h6;
  localparam logic [3:0] CAUSE_RDA = 4'h4;
  localparam logic [3:0] CAUSE_TMO = 4'hC;
  localparam logic [3:0] CAUSE_TX_HOLDING_EMPTY = 4'h2;

  // ************
  // reset values and counts
  // ************
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [3:0] IMR_RST = 4'h0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [15:0] DIV_HS_MASK = 16'h7FFF;
  localparam logic [15:0] DIV_ZERO_PERIOD = 16'h0003;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [7:0] SAMPLES_PER_BIT = 8'h10;
  localparam logic [2:0] TMO_CHARS = 3'h4;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one received character with its error flags
  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
    logic [7:0] data;
  } ubgfi_rxchar_s;

endpackage : ubgfi_pkg

/* File: hdl/ubgfi_uart.sv */
// serial channel rate divider with fifo interrupt and polled status logic
// Functional notes
// [RULE_01] Divider divides clock by 16-bit divisor 1..65535 for 16x sampling.
// [RULE_02] Divisor held in two writable byte latches.
// [RULE_03] Writing either latch reloads the counter at once.
// [RULE_04] Divisor zero divides by three.
// [RULE_05] Divisor one follows the inverted clock; here the output stays low every cycle.
// [RULE_06] Divisor two divides by two, even duty.
// [RULE_07] Divisor three or more: low two cycles, high the rest.
// [RULE_08] Data-available cause while fill at or above trigger.
// [RULE_09] Line status cause 06 outranks data-available 04.
// [RULE_10] Data ready sets on entry, clears when empty.
// [RULE_11] Timeout: data held, no arrival, no read for 4 chars.
// [RULE_12] Character times in sample ticks, second stop included.
// [RULE_13] One read clears an active timeout and restarts it.
// [RULE_14] Arrival or read restarts the timer.
// [RULE_15] Transmit-empty cause 02; write or cause read clears.
// [RULE_16] Empty indication delayed unless two bytes were held.
// [RULE_17] Fifo enable change raises transmit interrupt at once.
// [RULE_18] Timeout ranks as data-available, fifo empty as holding-empty.
// [RULE_19] Mask bits select polling, receiver and transmitter apart.
// [RULE_20] Polled line state: ready, errors, empties, fifo errors.
// [RULE_21] Polled mode shows no trigger or timeout.
// [RULE_22] High-speed bit: divisors 32770 and 32769 run faster.
// [RULE_23] Divisor select bit 7 maps offsets 0 and 1 to latches.
// [RULE_24] Divisor latches reset to zero.
module ubgfi_uart (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // axi4-lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // receive shifter side
  input wire logic rxCharValid,
  input wire ubgfi_pkg::ubgfi_rxchar_s rxChar,
  // transmit shifter side
  input wire logic txCharReady,
  output logic txCharValid,
  output logic [7:0] txCharData,
  input wire logic txShiftEmpty,
  // rate divider and interrupt
  output logic sampleTick,
  output logic baudOut,
  output logic irqPending
);

  // ************
  // helpers
  // ************
  // mapped register indices
  function automatic logic isMapped(input logic [3:0] idx);
    isMapped = (idx == ubgfi_pkg::IDX_DATA) || (idx == ubgfi_pkg::IDX_MASK) ||
      (idx == ubgfi_pkg::IDX_CAUSE) || (idx == ubgfi_pkg::IDX_LINE_CTRL) ||
      (idx == ubgfi_pkg::IDX_LINE_STATE) || (idx == ubgfi_pkg::IDX_CONFIG);
  endfunction : isMapped

  // effective divide period from latch value and high-speed bit
  function automatic logic [15:0] ratePeriod(input logic [15:0] dv, input logic hs);
    logic [15:0] d;
    d = hs ? (dv & ubgfi_pkg::DIV_HS_MASK) : dv;
    ratePeriod = (d == 16'h0000) ? ubgfi_pkg::DIV_ZERO_PERIOD : d;
  endfunction : ratePeriod

  // output level for a count position within a period
  function automatic logic rateLevel(input logic [15:0] cnt, input logic [15:0] per);
    if (per == 16'h0001) begin
      rateLevel = 1'b0;
    end else if (per == 16'h0002) begin
      rateLevel = (cnt == 16'h0000);
    end else begin
      rateLevel = (cnt < per - 16'h0002);
    end
  endfunction : rateLevel

  // ************
  // bus slave
  // ************
  logic awHeld, wHeld, wLane0, wrEn, wrStrobe, rdEn;
  logic [3:0] wrIdx, rdIdx;
  logic [7:0] wByte, rdByte;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrEn = awHeld && wHeld && !s_axi_bvalid;
  assign wrStrobe = wrEn && wLane0 && isMapped(wrIdx);
  assign rdEn = s_axi_arvalid && s_axi_arready;
  assign rdIdx = s_axi_araddr[5:2];

  // write address and data capture, in either order, then response
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrIdx <= 4'h0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ubgfi_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrIdx <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end
      if (wrEn) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(wrIdx) ? ubgfi_pkg::RESP_OKAY : ubgfi_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data capture and hold until taken
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ubgfi_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (rdEn) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= isMapped(rdIdx) ? ubgfi_pkg::RESP_OKAY : ubgfi_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************
  // control registers
  // ************
  logic [7:0] divLo, divHi, lineCtrl;
  logic [3:0] intMask;
  logic fifoEn, hsSel, divSel, divWrite, thrWrite, fcrWrite, fifoToggle;
  logic [1:0] trigSel;
  logic [15:0] next_div;

  // [RULE_23] divisor access select
  assign divSel = lineCtrl[ubgfi_pkg::LCR_DIV_SEL];
  assign divWrite = wrStrobe && divSel &&
    (wrIdx == ubgfi_pkg::IDX_DATA || wrIdx == ubgfi_pkg::IDX_MASK);
  assign thrWrite = wrStrobe && !divSel && wrIdx == ubgfi_pkg::IDX_DATA;
  assign fcrWrite = wrStrobe && wrIdx == ubgfi_pkg::IDX_CAUSE;
  assign fifoToggle = fcrWrite && (wByte[ubgfi_pkg::FCR_EN] != fifoEn);
  assign next_div = (wrIdx == ubgfi_pkg::IDX_DATA) ? {divHi, wByte} : {wByte, divLo};

  // software-written registers
  always_ff @(posedge clk) begin
    if (reset) begin
      // [RULE_24] divisor reset value
      divLo <= ubgfi_pkg::DIV_RST;
      divHi <= ubgfi_pkg::DIV_RST;
      lineCtrl <= ubgfi_pkg::LCR_RST;
      intMask <= ubgfi_pkg::IMR_RST;
      fifoEn <= 1'b0;
      trigSel <= ubgfi_pkg::TRIG_RST;
      hsSel <= 1'b0;
    end else if (clkEn && wrStrobe) begin
      // [RULE_02] separate byte latches
      if (divWrite) begin
        divLo <= next_div[7:0];
        divHi <= next_div[15:8];
      end
      if (!divSel && wrIdx == ubgfi_pkg::IDX_MASK) begin
        intMask <= wByte[3:0];
      end
      if (fcrWrite) begin
        fifoEn <= wByte[ubgfi_pkg::FCR_EN];
        trigSel <= wByte[ubgfi_pkg::FCR_TRIG +: 2];
      end
      if (wrIdx == ubgfi_pkg::IDX_LINE_CTRL) begin
        lineCtrl <= wByte;
      end
      if (wrIdx == ubgfi_pkg::IDX_CONFIG) begin
        hsSel <= wByte[0];
      end
    end
  end

  // ************
  // rate divider
  // ************
  logic [15:0] divCnt, period, next_divCnt;
  logic tick;

  // [RULE_22] high-speed bit folds the top divisor bit away
  assign period = ratePeriod({divHi, divLo}, hsSel);
  assign tick = (divCnt == 16'h0000);
  assign sampleTick = tick && clkEn;

  // [RULE_01] count down the period, tick at zero
  always_comb begin
    if (divWrite) begin
      // [RULE_03] immediate reload on latch write
      next_divCnt = ratePeriod(next_div, hsSel) - 16'h0001;
    end else if (tick || divCnt >= period) begin
      next_divCnt = period - 16'h0001;
    end else begin
      next_divCnt = divCnt - 16'h0001;
    end
  end

  // [RULE_04] [RULE_05] [RULE_06] [RULE_07] output shape per period
  always_ff @(posedge clk) begin
    if (reset) begin
      divCnt <= 16'h0000;
      baudOut <= 1'b0;
    end else if (clkEn) begin
      divCnt <= next_divCnt;
      baudOut <= rateLevel(next_divCnt, divWrite ? ratePeriod(next_div, hsSel) : period);
    end
  end

  // ************
  // character time
  // ************
  logic [3:0] charBits;
  logic [7:0] charTicks, threDelay;
  logic [10:0] tmoLimit;

  // [RULE_12] start, data, parity and all stop bits, in sample ticks
  assign charBits = 4'h7 + {2'h0, lineCtrl[1:0]} + {3'h0, lineCtrl[ubgfi_pkg::LCR_PAREN]} +
    {3'h0, lineCtrl[ubgfi_pkg::LCR_STOP2]};
  assign charTicks = 8'(charBits * 8'(ubgfi_pkg::SAMPLES_PER_BIT));
  assign tmoLimit = 11'(charTicks * 11'(ubgfi_pkg::TMO_CHARS));
  assign threDelay = charTicks - ubgfi_pkg::SAMPLES_PER_BIT;

  // ************
  // receive fifo
  // ************
  ubgfi_pkg::ubgfi_rxchar_s rxMem [16];
  logic [3:0] rxWr, rxRd;
  logic [4:0] rxCount, errCount, trigLevel;
  logic rxClear, rxPush, rxPop, overrun;
  logic [2:0] topErr;

  assign rxClear = fcrWrite && (wByte[ubgfi_pkg::FCR_RX_CLR] || fifoToggle);
  assign rxPush = rxCharValid && !rxClear &&
    (rxCount < (fifoEn ? ubgfi_pkg::FIFO_DEPTH : 5'h01));
  assign rxPop = rdEn && rdIdx == ubgfi_pkg::IDX_DATA && !divSel && rxCount != 5'h00 && !rxClear;
  assign topErr = (rxCount != 5'h00) ?
    {rxMem[rxRd].brk, rxMem[rxRd].frame, rxMem[rxRd].parity} : 3'h0;

  // storage, pointers and error count
  always_ff @(posedge clk) begin
    if (reset) begin
      rxWr <= 4'h0;
      rxRd <= 4'h0;
      rxCount <= 5'h00;
      errCount <= 5'h00;
    end else if (clkEn) begin
      if (rxClear) begin
        rxWr <= 4'h0;
        rxRd <= 4'h0;
        rxCount <= 5'h00;
        errCount <= 5'h00;
      end else begin
        if (rxPush) begin
          rxMem[rxWr] <= rxChar;
          rxWr <= rxWr + 4'h1;
        end
        if (rxPop) begin
          rxRd <= rxRd + 4'h1;
        end
        rxCount <= rxCount + {4'h0, rxPush} - {4'h0, rxPop};
        errCount <= errCount + {4'h0, rxPush && (rxChar.brk || rxChar.frame || rxChar.parity)}
          - {4'h0, rxPop && (topErr != 3'h0)};
      end
    end
  end

  // overrun when a character finds no room; set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      overrun <= 1'b0;
    end else if (clkEn) begin
      if (rxCharValid && !rxPush && !rxClear) begin
        overrun <= 1'b1;
      end else if (rdEn && rdIdx == ubgfi_pkg::IDX_LINE_STATE) begin
        overrun <= 1'b0;
      end
    end
  end

  // ************
  // receive timeout
  // ************
  logic [10:0] tmoCnt;
  logic tmoFlag;

  // timer counts sample ticks while characters wait unread
  always_ff @(posedge clk) begin
    if (reset) begin
      tmoCnt <= 11'h000;
      tmoFlag <= 1'b0;
    end else if (clkEn) begin
      // [RULE_14] arrival or read restarts the timer
      if (rxClear || rxPush || rxPop || rxCount == 5'h00) begin
        tmoCnt <= 11'h000;
      end else if (tick && !tmoFlag && tmoCnt < tmoLimit) begin
        tmoCnt <= tmoCnt + 11'h001;
      end
      // [RULE_13] one read clears an active timeout
      if (rxClear || rxPop || rxCount == 5'h00) begin
        tmoFlag <= 1'b0;
      // [RULE_11] stored data, no arrival, no read for four characters
      end else if (fifoEn && tmoCnt >= tmoLimit) begin
        tmoFlag <= 1'b1;
      end
    end
  end

  // ************
  // transmit fifo
  // ************
  logic [7:0] txMem [16];
  logic [3:0] txWr, txRd;
  logic [4:0] txCount;
  logic txClear, txPush, txPop;

  assign txClear = fcrWrite && (wByte[ubgfi_pkg::FCR_TX_CLR] || fifoToggle);
  assign txPush = thrWrite && !txClear &&
    (txCount < (fifoEn ? ubgfi_pkg::FIFO_DEPTH : 5'h01));
  assign txCharValid = (txCount != 5'h00);
  assign txPop = txCharValid && txCharReady && !txClear;
  assign txCharData = txMem[txRd];

  // storage and pointers; writes to a full fifo are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      txWr <= 4'h0;
      txRd <= 4'h0;
      txCount <= 5'h00;
    end else if (clkEn) begin
      if (txClear) begin
        txWr <= 4'h0;
        txRd <= 4'h0;
        txCount <= 5'h00;
      end else begin
        if (txPush) begin
          txMem[txWr] <= wByte;
          txWr <= txWr + 4'h1;
        end
        if (txPop) begin
          txRd <= txRd + 4'h1;
        end
        txCount <= txCount + {4'h0, txPush} - {4'h0, txPop};
      end
    end
  end

  // ************
  // transmit empty interrupt
  // ************
  logic threIrq, txTwo, dlyActive, lastOut, threSet, threClr;
  logic [7:0] dlyCnt;
  logic [3:0] cause;

  assign lastOut = txPop && txCount == 5'h01 && !txPush;
  // [RULE_16] immediate only when two bytes were held or in non-fifo mode
  // [RULE_17] fifo enable change raises it at once
  assign threSet = (lastOut && (txTwo || !fifoEn)) || fifoToggle ||
    (dlyActive && dlyCnt >= threDelay);
  // [RULE_15] cleared by holding write or by reading it as the cause
  assign threClr = thrWrite ||
    (rdEn && rdIdx == ubgfi_pkg::IDX_CAUSE && cause == ubgfi_pkg::CAUSE_TX_HOLDING_EMPTY);

  // flag, two-byte history and delay timer; set wins over clear for the flag and history, stop wins over start for the timer
  always_ff @(posedge clk) begin
    if (reset) begin
      threIrq <= 1'b0;
      txTwo <= 1'b0;
      dlyActive <= 1'b0;
      dlyCnt <= 8'h00;
    end else if (clkEn) begin
      if (threSet) begin
        threIrq <= 1'b1;
      end else if (threClr) begin
        threIrq <= 1'b0;
      end
      if (txCount >= 5'h02) begin
        txTwo <= 1'b1;
      end else if (threSet) begin
        txTwo <= 1'b0;
      end
      if (threSet || txPush || txClear) begin
        dlyActive <= 1'b0;
      end else if (lastOut) begin
        dlyActive <= 1'b1;
        dlyCnt <= 8'h00;
      end else if (dlyActive && tick) begin
        dlyCnt <= dlyCnt + 8'h01;
      end
    end
  end

  // ************
  // cause and line state
  // ************
  logic lsiPend, rdaPend, tmoPend, threPend;
  logic [7:0] lineState;

  // trigger level from the fifo control selection
  always_comb begin
    case (trigSel)
      2'h0: trigLevel = ubgfi_pkg::TRIG_L0;
      2'h1: trigLevel = ubgfi_pkg::TRIG_L1;
      2'h2: trigLevel = ubgfi_pkg::TRIG_L2;
      default: trigLevel = ubgfi_pkg::TRIG_L3;
    endcase
  end

  // [RULE_19] each source gated by its mask bit, timeout by the data-available bit
  // [RULE_21] masked receive shows no trigger or timeout
  assign lsiPend = intMask[ubgfi_pkg::IMR_LSI] && (overrun || topErr != 3'h0);
  // [RULE_08] fill at or above trigger
  assign rdaPend = intMask[ubgfi_pkg::IMR_RDA] &&
    (fifoEn ? (rxCount >= trigLevel) : (rxCount != 5'h00));
  assign tmoPend = intMask[ubgfi_pkg::IMR_RDA] && tmoFlag;
  assign threPend = intMask[ubgfi_pkg::IMR_TX_HOLDING_EMPTY] && threIrq;

  // [RULE_09] [RULE_18] fixed priority of causes
  always_comb begin
    if (lsiPend) begin
      cause = ubgfi_pkg::CAUSE_LSI;
    end else if (rdaPend) begin
      cause = ubgfi_pkg::CAUSE_RDA;
    end else if (tmoPend) begin
      cause = ubgfi_pkg::CAUSE_TMO;
    end else if (threPend) begin
      cause = ubgfi_pkg::CAUSE_TX_HOLDING_EMPTY;
    end else begin
      cause = ubgfi_pkg::CAUSE_NONE;
    end
  end

  assign irqPending = (cause != ubgfi_pkg::CAUSE_NONE);

  // [RULE_10] [RULE_20] line state bits
  assign lineState = {fifoEn && errCount != 5'h00, txCount == 5'h00 && txShiftEmpty,
    txCount == 5'h00, topErr, overrun, rxCount != 5'h00};

  // read value by index
  always_comb begin
    case (rdIdx)
      ubgfi_pkg::IDX_DATA: rdByte = divSel ? divLo : rxMem[rxRd].data;
      ubgfi_pkg::IDX_MASK: rdByte = divSel ? divHi : {4'h0, intMask};
      ubgfi_pkg::IDX_CAUSE: rdByte = {fifoEn, fifoEn, 2'h0, cause};
      ubgfi_pkg::IDX_LINE_CTRL: rdByte = lineCtrl;
      ubgfi_pkg::IDX_LINE_STATE: rdByte = lineState;
      ubgfi_pkg::IDX_CONFIG: rdByte = {7'h00, hsSel};
      default: rdByte = 8'h00;
    endcase
  end

endmodule : ubgfi_uart

/* File: bench/ubgfi_uart_chk.sv */
// concurrent checks on the ports of the rate divider and fifo status block
module ubgfi_uart_chk (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // axi4-lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // shifter sides
  input wire logic rxCharValid,
  input wire ubgfi_pkg::ubgfi_rxchar_s rxChar,
  input wire logic txCharReady,
  input wire logic txCharValid,
  input wire logic [7:0] txCharData,
  input wire logic txShiftEmpty,
  // divider and interrupt
  input wire logic sampleTick,
  input wire logic baudOut,
  input wire logic irqPending
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  // both halves of a write taken at one edge
  sequence wrBoth;
    clkEn && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read request taken
  sequence rdTaken;
    clkEn && s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wrBoth |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_tx_head_hold: assert property (
    txCharValid && !txCharReady |=> txCharValid && $stable(txCharData))
    else $error("transmit head lost before taken");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset && clkEn |=> !s_axi_bvalid && !s_axi_rvalid && !irqPending && !txCharValid)
    else $error("outputs active after reset");
endmodule : ubgfi_uart_chk

bind ubgfi_uart ubgfi_uart_chk chk (.*);

/* File: bench/ubgfi_shift_model.sv */
// serial shifter side model: hands over received characters, takes bytes
module ubgfi_shift_model (
  // clock
  input wire logic clk,
  // receive side
  output logic rxCharValid,
  output ubgfi_pkg::ubgfi_rxchar_s rxChar,
  // transmit side
  input wire logic txCharValid,
  input wire logic [7:0] txCharData,
  output logic txCharReady,
  output logic txShiftEmpty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lastTx = 8'h00;
  logic [4:0] busyCnt = 5'h00;
  initial begin
    rxCharValid = 1'b0;
    rxChar = '0;
    txCharReady = 1'b0;
  end
  task automatic push(input ubgfi_pkg::ubgfi_rxchar_s c);
    @(posedge clk);
    rxCharValid <= 1'b1;
    rxChar <= c;
    @(posedge clk);
    rxCharValid <= 1'b0;
    rxChar <= ~c; // stale bus shows no old value
  endtask : push
  // slow shifter: ready every other cycle, busy 20 cycles per byte
  always @(posedge clk) begin
    txCharReady <= !txCharReady;
    if (txCharValid && txCharReady) begin
      lastTx <= txCharData;
      busyCnt <= 5'h14;
    end else if (busyCnt != 5'h00) begin
      busyCnt <= busyCnt - 5'h01;
    end
  end
  assign txShiftEmpty = (busyCnt == 5'h00);
endmodule : ubgfi_shift_model

/* File: bench/ubgfi_uart_bench.sv */
// self-checking bench for the rate divider and fifo status block
module ubgfi_uart_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rxCharValid, txCharReady, txCharValid, txShiftEmpty;
  logic sampleTick, baudOut, irqPending;
  ubgfi_pkg::ubgfi_rxchar_s rxChar;
  logic [7:0] txCharData;
  int mismatches = 0, comparisons = 0;

  ubgfi_uart dut (.*);
  ubgfi_shift_model part (.*);

  // clock generation
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // bus write: each channel released at the edge that takes it
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  // bus read, compared with the expected byte and response
  task automatic rchk(input string nm, input logic [3:0] idx, input logic [7:0] exp,
                      input logic [1:0] er = ubgfi_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(nm, s_axi_rdata, {24'h000000, exp});
    check(nm, {30'h00000000, s_axi_rresp}, {30'h00000000, er});
  endtask : rchk

  task automatic irq(input logic e);
    @(negedge clk);
    check("irq", {31'h00000000, irqPending}, {31'h00000000, e});
  endtask : irq

  task automatic rx(input logic [7:0] d, input logic par = 1'b0);
    part.push({2'b00, par, d});
  endtask : rx

  // one divider period between ticks and its low cycles
  task automatic period(input logic [15:0] p, input logic [15:0] lo);
    logic [15:0] n = 16'h0000;
    logic [15:0] l = 16'h0000;
    @(negedge clk);
    while (!sampleTick) @(negedge clk);
    do begin
      @(negedge clk);
      n++;
      if (!baudOut) l++;
    end while (!sampleTick);
    check("period", {16'h0000, n}, {16'h0000, p});
    check("low cycles", {16'h0000, l}, {16'h0000, lo});
  endtask : period

  task automatic t_reset();
    period(16'h0003, 16'h0002);
    rchk("line state", ubgfi_pkg::IDX_LINE_STATE, 8'h60);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'h01);
    rchk("unmapped", 4'h4, 8'h00, ubgfi_pkg::RESP_SLVERR);
  endtask : t_reset

  task automatic t_divider();
    logic [32:0] tab [7] = '{{1'b0, 16'h0000, 16'h0003},
                            {1'b0, 16'h0001, 16'h0001},
                            {1'b0, 16'h0002, 16'h0002},
                            {1'b0, 16'h0005, 16'h0005},
                            {1'b0, 16'h0102, 16'h0102},
                            {1'b1, 16'h8002, 16'h0002},
                            {1'b1, 16'h8001, 16'h0001}};
    foreach (tab[i]) begin
      wr(ubgfi_pkg::IDX_LINE_CTRL, 8'h80);
      wr(ubgfi_pkg::IDX_DATA, tab[i][23:16]);
      wr(ubgfi_pkg::IDX_MASK, tab[i][31:24]);
      wr(ubgfi_pkg::IDX_LINE_CTRL, 8'h00);
      wr(ubgfi_pkg::IDX_CONFIG, {7'h00, tab[i][32]});
      period(tab[i][15:0], (tab[i][15:0] < 16'h0003) ? 16'h0001 : 16'h0002);
    end
    wr(ubgfi_pkg::IDX_CONFIG, 8'h00);
  endtask : t_divider

  task automatic t_trigger();
    wr(ubgfi_pkg::IDX_CAUSE, 8'h41);
    wr(ubgfi_pkg::IDX_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      irq(1'b0);
      rx(8'h10 + i[7:0]);
    end
    irq(1'b1);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'hC4);
    rchk("data", ubgfi_pkg::IDX_DATA, 8'h10);
    irq(1'b0);
    wr(ubgfi_pkg::IDX_MASK, 8'h00);
    rx(8'h14);
    irq(1'b0);
    rchk("line state", ubgfi_pkg::IDX_LINE_STATE, 8'h61);
    for (int i = 1; i < 5; i++) begin
      rchk("data", ubgfi_pkg::IDX_DATA, 8'h10 + i[7:0]);
    end
    rchk("line state", ubgfi_pkg::IDX_LINE_STATE, 8'h60);
  endtask : t_trigger

  task automatic t_priority();
    wr(ubgfi_pkg::IDX_CAUSE, 8'h01);
    wr(ubgfi_pkg::IDX_MASK, 8'h05);
    rx(8'h55, 1'b1);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'hC6);
    rchk("line state", ubgfi_pkg::IDX_LINE_STATE, 8'hE5);
    rchk("data", ubgfi_pkg::IDX_DATA, 8'h55);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'hC1);
  endtask : t_priority

  task automatic t_timeout();
    wr(ubgfi_pkg::IDX_LINE_CTRL, 8'h80);
    wr(ubgfi_pkg::IDX_DATA, 8'h01);
    wr(ubgfi_pkg::IDX_MASK, 8'h00);
    wr(ubgfi_pkg::IDX_LINE_CTRL, 8'h04);
    wr(ubgfi_pkg::IDX_CAUSE, 8'h81);
    wr(ubgfi_pkg::IDX_MASK, 8'h01);
    rx(8'h21);
    repeat (300) @(posedge clk);
    rx(8'h22);
    repeat (480) @(posedge clk);
    irq(1'b0);
    repeat (60) @(posedge clk);
    irq(1'b1);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'hCC);
    rchk("data", ubgfi_pkg::IDX_DATA, 8'h21);
    irq(1'b0);
    rchk("data", ubgfi_pkg::IDX_DATA, 8'h22);
  endtask : t_timeout

  task automatic t_tx();
    wr(ubgfi_pkg::IDX_MASK, 8'h02);
    irq(1'b1);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'hC2);
    rchk("cause", ubgfi_pkg::IDX_CAUSE, 8'hC1);
    wr(ubgfi_pkg::IDX_DATA, 8'hA5);
    repeat (60) @(posedge clk);
    check("tx byte", {24'h000000, part.lastTx}, 32'h000000A5);
    irq(1'b0);
    repeat (120) @(posedge clk);
    irq(1'b1);
    wr(ubgfi_pkg::IDX_DATA, 8'h5A);
    irq(1'b0);
  endtask : t_tx

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_divider();
    t_trigger();
    t_priority();
    t_timeout();
    t_tx();
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : ubgfi_uart_bench
